// [psif_pkg.sv]
// Behaviour
// - linear regulator status: linreg3 dropout/short/uv/overtemp, linreg2 uv/overtemp, linreg1 uv/overtemp
// - switch/buck status: buck-boost fault bit 7, buck3..1 overtemp bits 2..0
// - bit 6 of switch/buck status is OR of three load switch overtemps
// - bits 5..3 report load switch 3..1 start-up timeout
// - battery good bit 7 reads 1 above threshold or without charger input
// - step charge bit 6, meaningful only with valid input and charger enabled
// - regulation bit 5, valid additionally only while system limit flag is 0
// - recharge bit 4, same validity as regulation bit
// - harvester compare bit 3, valid only while harvester enable is 1
// - flag register one: bit 7 zone change, bit 4 timeout change, bit 0 state change
// - flag register two: each bit set on change of same charger input status bit
// - flags stay set until their register is read; read returns then clears, unless a change lands in the read cycle
// - charger input status: system limit bit 7 down to thermal shutdown bit 0
// - each flag has a mask bit; 0 masks, 1 unmasks
package psif_pkg;
    localparam logic [7:0] PSIF_LINREG_STATUS_ADDR = 8'h03;
    localparam logic [7:0] PSIF_SWITCH_STATUS_ADDR = 8'h04;
    localparam logic [7:0] PSIF_CHGCMP_STATUS_ADDR = 8'h05;
    localparam logic [7:0] PSIF_STATE_FLAGS_ADDR = 8'h07;
    localparam logic [7:0] PSIF_INPUT_FLAGS_ADDR = 8'h08;
    localparam logic [7:0] PSIF_RESET_BYTE = 8'h00;
    localparam int PSIF_ZONE_FLAG_BIT = 7;
    localparam int PSIF_TIMEOUT_FLAG_BIT = 4;
    localparam int PSIF_STATE_FLAG_BIT = 0;
    localparam logic [7:0] PSIF_STATE_FLAGS_USED = 8'h91;
endpackage

// [psif_change_flag.sv]
// one sticky change flag; a change in the clearing cycle wins over the clear
module psif_change_flag
    import psif_pkg::*;
(
    input wire logic sys_clk_in, // system clock
    input wire logic reset_n_in, // async reset, active low
    input wire logic change_in, // watched field changed this cycle
    input wire logic clear_in, // register read, clear the flag
    output logic flag_out // sticky flag
);
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            flag_out <= 1'b0;
        end else if (change_in) begin
            flag_out <= 1'b1;
        end else if (clear_in) begin
            flag_out <= 1'b0;
        end
    end
endmodule

// [psif_status_flags.sv]
module psif_status_flags
    import psif_pkg::*;
(
    input wire logic sys_clk_in, // 250 MHz system clock
    input wire logic reset_n_in, // async reset, active low
    input wire logic linreg3_dropout_in, // linear regulator 3 dropout
    input wire logic linreg3_short_in, // linear regulator 3 short circuit
    input wire logic linreg3_undervoltage_in, // linear regulator 3 undervoltage lockout
    input wire logic linreg3_overtemp_in, // linear regulator 3 thermal shutdown
    input wire logic linreg2_undervoltage_in, // linear regulator 2 undervoltage
    input wire logic linreg2_overtemp_in, // linear regulator 2 thermal shutdown
    input wire logic linreg1_undervoltage_in, // linear regulator 1 undervoltage
    input wire logic linreg1_overtemp_in, // linear regulator 1 thermal shutdown
    input wire logic buckboost_fault_in, // buck-boost fault
    input wire logic [2:0] switch_overtemp_in, // load switch 3..1 thermal shutdown
    input wire logic switch3_start_timeout_in, // load switch 3 start timeout
    input wire logic switch2_start_timeout_in, // load switch 2 start timeout
    input wire logic switch1_start_timeout_in, // load switch 1 start timeout
    input wire logic buck3_overtemp_in, // buck 3 thermal shutdown
    input wire logic buck2_overtemp_in, // buck 2 thermal shutdown
    input wire logic buck1_overtemp_in, // buck 1 thermal shutdown
    input wire logic battery_good_in, // battery above undervoltage threshold
    input wire logic step_charge_active_in, // step-charge reduction active
    input wire logic battery_at_regulation_in, // battery at or above regulation
    input wire logic battery_above_recharge_in, // battery at or above recharge
    input wire logic harvester_battery_compare_in, // battery above harvester level
    input wire logic harvester_enable_in, // harvester interaction enabled
    input wire logic charger_enable_in, // charger enabled
    input wire logic [2:0] thermistor_zone_in, // thermistor zone field
    input wire logic const_current1_timeout_in, // constant current 1 timeout
    input wire logic [3:0] charger_state_in, // charger state field
    input wire logic [7:0] charger_input_status_in, // system limit .. thermal shutdown
    input wire logic [7:0] state_flags_mask_in, // mask for flag register one
    input wire logic [7:0] input_flags_mask_in, // mask for flag register two
    input wire logic rd_en_in, // register read strobe, one cycle
    input wire logic [7:0] rd_addr_in, // register address
    output logic [7:0] rd_data_out, // read data, one cycle after strobe
    output logic irq_out // interrupt, active high
);
    //////////////////////////////////////////////////////////////////////
    logic [7:0] linreg_d;
    logic [7:0] switch_d;
    logic [7:0] chgcmp_d;
    logic input_present;
    logic charge_valid;
    logic vreg_valid;
    logic [7:0] linreg_q;
    logic [7:0] switch_q;
    logic [7:0] chgcmp_q;
    logic [2:0] zone_q;
    logic timeout_q;
    logic [3:0] state_q;
    logic [7:0] input_q;
    logic [7:0] state_change;
    logic [7:0] state_flags;
    logic [7:0] input_flags;
    logic rd_state;
    logic rd_input;

    always_comb begin
        linreg_d = {linreg3_dropout_in, linreg3_short_in, linreg3_undervoltage_in, linreg3_overtemp_in,
            linreg2_undervoltage_in, linreg2_overtemp_in,
            linreg1_undervoltage_in, linreg1_overtemp_in};
        switch_d = {buckboost_fault_in, |switch_overtemp_in,
            switch3_start_timeout_in, switch2_start_timeout_in, switch1_start_timeout_in,
            buck3_overtemp_in, buck2_overtemp_in, buck1_overtemp_in};
    end

    // overvoltage bit 4, input-valid bit 3 must read 01
    assign input_present = !charger_input_status_in[4] && charger_input_status_in[3];
    assign charge_valid = input_present && charger_enable_in;
    assign vreg_valid = charge_valid && !charger_input_status_in[7];

    // invalid step, regulation, recharge and harvester results read 0 rather than stale values; battery good reads 1 without input
    always_comb begin
        chgcmp_d = PSIF_RESET_BYTE;
        chgcmp_d[7] = battery_good_in || !input_present;
        chgcmp_d[6] = step_charge_active_in && charge_valid;
        chgcmp_d[5] = battery_at_regulation_in && vreg_valid;
        chgcmp_d[4] = battery_above_recharge_in && vreg_valid;
        chgcmp_d[3] = harvester_battery_compare_in && harvester_enable_in;
    end

    //////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            linreg_q <= PSIF_RESET_BYTE;
            switch_q <= PSIF_RESET_BYTE;
            chgcmp_q <= PSIF_RESET_BYTE;
        end else begin
            linreg_q <= linreg_d;
            switch_q <= switch_d;
            chgcmp_q <= chgcmp_d;
        end
    end

    // previous-cycle copies; reset to 0 so a nonzero field after reset flags once
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            zone_q <= 3'h0;
            timeout_q <= 1'b0;
            state_q <= 4'h0;
            input_q <= PSIF_RESET_BYTE;
        end else begin
            zone_q <= thermistor_zone_in;
            timeout_q <= const_current1_timeout_in;
            state_q <= charger_state_in;
            input_q <= charger_input_status_in;
        end
    end

    always_comb begin
        state_change = PSIF_RESET_BYTE;
        state_change[PSIF_ZONE_FLAG_BIT] = zone_q != thermistor_zone_in;
        state_change[PSIF_TIMEOUT_FLAG_BIT] = timeout_q != const_current1_timeout_in;
        state_change[PSIF_STATE_FLAG_BIT] = state_q != charger_state_in;
    end

    assign rd_state = rd_en_in && (rd_addr_in == PSIF_STATE_FLAGS_ADDR);
    assign rd_input = rd_en_in && (rd_addr_in == PSIF_INPUT_FLAGS_ADDR);

    //////////////////////////////////////////////////////////////////////
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_flag
            if (PSIF_STATE_FLAGS_USED[gi]) begin : g_used
                psif_change_flag u_state (
                    .sys_clk_in(sys_clk_in),
                    .reset_n_in(reset_n_in),
                    .change_in(state_change[gi]),
                    .clear_in(rd_state),
                    .flag_out(state_flags[gi])
                );
            end else begin : g_unused
                assign state_flags[gi] = 1'b0;
            end
            psif_change_flag u_input (
                .sys_clk_in(sys_clk_in),
                .reset_n_in(reset_n_in),
                .change_in(input_q[gi] != charger_input_status_in[gi]),
                .clear_in(rd_input),
                .flag_out(input_flags[gi])
            );
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////
    // read returns the flag value before the clear takes effect
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_data_out <= PSIF_RESET_BYTE;
        end else if (rd_en_in) begin
            unique case (rd_addr_in)
                PSIF_LINREG_STATUS_ADDR: rd_data_out <= linreg_q;
                PSIF_SWITCH_STATUS_ADDR: rd_data_out <= switch_q;
                PSIF_CHGCMP_STATUS_ADDR: rd_data_out <= chgcmp_q;
                PSIF_STATE_FLAGS_ADDR: rd_data_out <= state_flags;
                PSIF_INPUT_FLAGS_ADDR: rd_data_out <= input_flags;
                default: rd_data_out <= PSIF_RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(state_flags & state_flags_mask_in) | |(input_flags & input_flags_mask_in);
        end
    end

    //////////////////////////////////////////////////////////////////////
    sequence s_state_read;
        rd_state && !(|state_change);
    endsequence
    sequence s_input_read;
        rd_input && input_q == charger_input_status_in;
    endsequence

    a_linreg_status: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        rd_en_in && rd_addr_in == PSIF_LINREG_STATUS_ADDR |=> rd_data_out == $past(linreg_q))
        else $error("linear regulator status read mismatch");
    a_buck_fault: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        ##1 switch_q[7] == $past(buckboost_fault_in) && switch_q[0] == $past(buck1_overtemp_in))
        else $error("buck status bit mismatch");
    a_switch_or: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        ##1 switch_q[6] == $past(|switch_overtemp_in))
        else $error("load switch overtemp summary wrong");
    a_switch_timeout: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        ##1 switch_q[5] == $past(switch3_start_timeout_in) && switch_q[3] == $past(switch1_start_timeout_in))
        else $error("switch timeout bit wrong");
    a_battery_good: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        !input_present |=> chgcmp_q[7] && chgcmp_q[2:0] == 3'h0)
        else $error("battery good not forced without input");
    a_step_valid: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        !charger_enable_in |=> !chgcmp_q[6])
        else $error("step charge shown while charger off");
    a_reg_valid: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        charger_input_status_in[7] |=> !chgcmp_q[5] && !chgcmp_q[4])
        else $error("regulation shown while system limited");
    a_harv_valid: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        harvester_enable_in |=> chgcmp_q[3] == $past(harvester_battery_compare_in))
        else $error("harvester compare wrong");
    a_zone_flag: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        zone_q != thermistor_zone_in |=> state_flags[PSIF_ZONE_FLAG_BIT])
        else $error("zone change not flagged");
    a_input_flag: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        input_q[3] != charger_input_status_in[3] |=> input_flags[3])
        else $error("input valid change not flagged");
    a_read_clears: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        s_state_read |=> state_flags == PSIF_RESET_BYTE && rd_data_out == $past(state_flags))
        else $error("state flags not returned then cleared");
    a_irq_level: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        ##1 irq_out == $past(|(input_flags & input_flags_mask_in) | |(state_flags & state_flags_mask_in)))
        else $error("interrupt level wrong");
    a_recharge_valid: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        vreg_valid |=> chgcmp_q[4] == $past(battery_above_recharge_in))
        else $error("recharge compare wrong while valid");
    a_overvolt_forces: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        charger_input_status_in[4] |=> chgcmp_q[7] && !chgcmp_q[6] && !chgcmp_q[5])
        else $error("overvoltage not treated as no input");
    a_flag_sticky: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        state_flags[PSIF_TIMEOUT_FLAG_BIT] && !rd_state |=> state_flags[PSIF_TIMEOUT_FLAG_BIT])
        else $error("timeout flag dropped without a read");
    a_input_clears: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        s_input_read |=> input_flags == PSIF_RESET_BYTE)
        else $error("input flags not cleared by read");
endmodule

// [psif_host_model.sv]
module psif_host_model (
    input wire logic sys_clk_in, // system clock
    input wire logic [7:0] rd_data_in, // read data from device
    output logic rd_en_out, // one-cycle read strobe
    output logic [7:0] rd_addr_out // register address
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rd_en_out = 1'b0;
        rd_addr_out = 8'h00;
    end
    // strobe one cycle, take the byte in the answer cycle
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge sys_clk_in);
        rd_en_out = 1'b1;
        rd_addr_out = addr;
        @(negedge sys_clk_in);
        rd_en_out = 1'b0;
        // idle address scrambled so a stale decode cannot pass
        rd_addr_out = ~addr;
        data = rd_data_in;
    endtask
endmodule

// [tb_pmic_status_interrupt_flags.sv]
module tb_pmic_status_interrupt_flags import psif_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] lin = 8'h00, cis = 8'h00, m0 = 8'h00, m1 = 8'h00, d, e4, e5, rd_data, rd_addr;
    logic [9:0] swv = 10'h000;
    logic [6:0] cmp = 7'h00;
    logic [2:0] zone = 3'h0;
    logic [3:0] cst = 4'h0;
    logic cc1 = 1'b0, rd_en, irq;
    int bad_count = 0, compares = 0, cycles = 0;
    // regulator byte, switch/buck raw bits, comparator bits, charger input status, expected 0x04, expected 0x05
    logic [48:0] rows [6] = '{{8'hA5, 10'h22A, 7'h7F, 8'h08, 8'hAA, 8'hF8},
        {8'h5A, 10'h115, 7'h3D, 8'h08, 8'h55, 8'h70},
        {8'hFF, 10'h080, 7'h3F, 8'h88, 8'h40, 8'h48},
        {8'h00, 10'h040, 7'h3F, 8'h18, 8'h40, 8'h88},
        {8'h81, 10'h3FF, 7'h3E, 8'h08, 8'hFF, 8'h08},
        {8'h3C, 10'h000, 7'h03, 8'h00, 8'h00, 8'h80}};
    logic [7:0] fbit [3] = '{8'h80, 8'h10, 8'h01};
    always #2 clk = ~clk;
    psif_status_flags dut (.sys_clk_in(clk), .reset_n_in(rst_n),
        .linreg3_dropout_in(lin[7]), .linreg3_short_in(lin[6]), .linreg3_undervoltage_in(lin[5]),
        .linreg3_overtemp_in(lin[4]), .linreg2_undervoltage_in(lin[3]), .linreg2_overtemp_in(lin[2]),
        .linreg1_undervoltage_in(lin[1]), .linreg1_overtemp_in(lin[0]), .buckboost_fault_in(swv[9]),
        .switch_overtemp_in(swv[8:6]), .switch3_start_timeout_in(swv[5]), .switch2_start_timeout_in(swv[4]),
        .switch1_start_timeout_in(swv[3]), .buck3_overtemp_in(swv[2]), .buck2_overtemp_in(swv[1]),
        .buck1_overtemp_in(swv[0]), .battery_good_in(cmp[6]), .step_charge_active_in(cmp[5]),
        .battery_at_regulation_in(cmp[4]), .battery_above_recharge_in(cmp[3]),
        .harvester_battery_compare_in(cmp[2]), .harvester_enable_in(cmp[1]), .charger_enable_in(cmp[0]),
        .thermistor_zone_in(zone), .const_current1_timeout_in(cc1), .charger_state_in(cst),
        .charger_input_status_in(cis), .state_flags_mask_in(m0), .input_flags_mask_in(m1),
        .rd_en_in(rd_en), .rd_addr_in(rd_addr), .rd_data_out(rd_data), .irq_out(irq));
    psif_host_model host (.sys_clk_in(clk), .rd_data_in(rd_data), .rd_en_out(rd_en), .rd_addr_out(rd_addr));
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        host.read_reg(a, d);
        check(d, e);
    endtask
    task automatic give_verdict;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // a hang is cut short well above the roughly 150 cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        rd(PSIF_LINREG_STATUS_ADDR, PSIF_RESET_BYTE);
        rd(PSIF_SWITCH_STATUS_ADDR, PSIF_RESET_BYTE);
        rd(PSIF_CHGCMP_STATUS_ADDR, 8'h80);
        rd(PSIF_STATE_FLAGS_ADDR, PSIF_RESET_BYTE);
        rd(PSIF_INPUT_FLAGS_ADDR, PSIF_RESET_BYTE);
        rd(8'h06, 8'h00);
        foreach (rows[i]) begin
            @(negedge clk);
            {lin, swv, cmp, cis, e4, e5} = rows[i];
            rd(PSIF_LINREG_STATUS_ADDR, lin);
            rd(PSIF_SWITCH_STATUS_ADDR, e4);
            rd(PSIF_CHGCMP_STATUS_ADDR, e5);
        end
        rd(PSIF_INPUT_FLAGS_ADDR, 8'h98);
        rd(PSIF_INPUT_FLAGS_ADDR, 8'h00);
        rd(PSIF_STATE_FLAGS_ADDR, 8'h00);
        // two changes that restore the field must still leave the flag up
        for (int k = 0; k < 3; k++) begin
            repeat (2) begin
                @(negedge clk);
                case (k)
                    0: zone[2] = ~zone[2];
                    1: cc1 = ~cc1;
                    default: cst[3] = ~cst[3];
                endcase
            end
            rd(PSIF_STATE_FLAGS_ADDR, fbit[k]);
            rd(PSIF_STATE_FLAGS_ADDR, 8'h00);
        end
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            cis[i] = ~cis[i];
            rd(PSIF_INPUT_FLAGS_ADDR, 8'h01 << i);
            rd(PSIF_INPUT_FLAGS_ADDR, 8'h00);
        end
        @(negedge clk);
        zone = zone + 3'h1;
        m0 = 8'h7F;
        m1 = 8'h01;
        cis[5] = ~cis[5];
        repeat (3) @(negedge clk);
        check({7'h00, irq}, 8'h00);
        m0 = 8'h80;
        repeat (2) @(negedge clk);
        check({7'h00, irq}, 8'h01);
        rd(PSIF_STATE_FLAGS_ADDR, 8'h80);
        rd(PSIF_INPUT_FLAGS_ADDR, 8'h20);
        @(negedge clk);
        check({7'h00, irq}, 8'h00);
        cis[0] = ~cis[0];
        repeat (3) @(negedge clk);
        check({7'h00, irq}, 8'h01);
        rd(PSIF_INPUT_FLAGS_ADDR, 8'h01);
        // a change landing on the clearing read must survive it
        fork
            host.read_reg(PSIF_STATE_FLAGS_ADDR, d);
            begin
                @(negedge clk);
                cc1 = ~cc1;
            end
        join
        check(d, 8'h00);
        rd(PSIF_STATE_FLAGS_ADDR, 8'h10);
        zone = ~zone;
        repeat (3) @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        check(rd_data, 8'h00);
        check({7'h00, irq}, 8'h00);
        rst_n = 1'b1;
        rd(PSIF_LINREG_STATUS_ADDR, lin);
        // previous copies restart at zero, so fields left nonzero flag once
        rd(PSIF_STATE_FLAGS_ADDR, 8'h90);
        rd(PSIF_INPUT_FLAGS_ADDR, 8'hDE);
        give_verdict();
    end
endmodule
